//--- include/dscp_map.svh
`ifndef DSCP_MAP_SVH
`define DSCP_MAP_SVH
// Register addresses (7-bit)
`define DSCP_ADDR_PD_MASK 7'h10
`define DSCP_ADDR_STATUS_SEL 7'h21
`define DSCP_ADDR_BALUN 7'h30
`define DSCP_ADDR_BB_BW 7'h34
// Frame layout
`define DSCP_ADDR_BITS 7
`define DSCP_DATA_BITS 16
`define DSCP_HDR_BITS 8
// Field positions
`define DSCP_BIAS_HI 11
`define DSCP_BIAS_LO 10
`define DSCP_BW_HI 9
`define DSCP_BW_LO 8
`define DSCP_BAL_IN_HI 7
`define DSCP_BAL_IN_LO 4
`define DSCP_BAL_OUT_HI 3
`define DSCP_BAL_OUT_LO 0
`define DSCP_SSEL_HI 6
`define DSCP_SSEL_LO 4
// Status select codes
`define DSCP_SSEL_LOCK 3'h1
`define DSCP_SSEL_REF 3'h0
// Reset values
`define DSCP_RST_PD_MASK 16'h0000
`define DSCP_RST_BALUN 16'h0000
`define DSCP_RST_BB_BW 16'h0400
`define DSCP_RST_STATUS_SEL 16'h0010
`endif

//--- include/dscp_pkg.sv
package dscp_pkg;
  // Frame phase of the serial port
  typedef enum logic [1:0] {
    DSCP_IDLE,
    DSCP_HEAD,
    DSCP_DATA
  } dscp_phase_t;

  // Settings driven to the analog core
  typedef struct packed {
    logic [1:0] buffer_bias_code;
    logic [1:0] bandwidth_mode;
    logic [3:0] balun_input_cap_code;
    logic [3:0] balun_output_cap_code;
    logic [15:0] block_enable;
    logic rf_input_first;
    logic rf_input_second;
    logic status_output_pin;
  } dscp_ctrl_t;

  // Whole state of the block
  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [2:0] csn_sync;
    logic [1:0] sdio_sync;
    logic [1:0] external_enable_pin_sync;
    logic [1:0] rfsel_sync;
    logic [1:0] lock_sync;
    logic [1:0] ref_sync;
    dscp_phase_t phase;
    logic [4:0] bit_cnt;
    logic [7:0] header;
    logic [15:0] shreg;
    logic [4:0] data_cnt;
    logic [15:0] rdata;
    logic sdio_out;
    logic sdio_oe;
    logic [15:0] power_down_mask;
    logic [15:0] balun_capacitor_codes;
    logic [15:0] baseband_bias_and_bandwidth;
    logic [15:0] status_select_reg;
    dscp_ctrl_t ctrl;
  } dscp_state_t;
endpackage : dscp_pkg

//--- design/dscp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dscp_map.svh"

module dscp_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Serial port pins
  input wire logic sclk_i,
  input wire logic csn_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  // Device pins and core status
  input wire logic external_enable_pin_i,
  input wire logic rf_input_select_pin_i,
  input wire logic lock_detect_i,
  input wire logic ref_clk_div_i,
  // Settings to the analog core
  output dscp_pkg::dscp_ctrl_t ctrl_o
);

  // Current and next state
  dscp_pkg::dscp_state_t s_q;
  dscp_pkg::dscp_state_t s_d;

  // Readback mux; only the mapped settings registers answer, others read zero
  // Called once per frame, read or write, when the header completes, so bit 15 is ready early
  function automatic logic [15:0] rd_mux(input logic [6:0] a, input dscp_pkg::dscp_state_t s);
    case (a)
      `DSCP_ADDR_PD_MASK: rd_mux = s.power_down_mask;
      `DSCP_ADDR_BALUN: rd_mux = s.balun_capacitor_codes;
      `DSCP_ADDR_BB_BW: rd_mux = s.baseband_bias_and_bandwidth;
      `DSCP_ADDR_STATUS_SEL: rd_mux = s.status_select_reg;
      default: rd_mux = 16'h0000;
    endcase
  endfunction : rd_mux

  // Edges seen from synchronised pins (stage 1 and 2 only)
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic cs_rise;
  logic is_read;
  logic [15:0] wval;
  // Stages 1 and 2 compared; stage 0 is never read by logic
  assign sclk_rise = s_q.sclk_sync[1] & ~s_q.sclk_sync[2];
  assign sclk_fall = ~s_q.sclk_sync[1] & s_q.sclk_sync[2];
  // Select is active low; a rising select closes the frame
  assign cs_active = ~s_q.csn_sync[1];
  assign cs_rise = s_q.csn_sync[1] & ~s_q.csn_sync[2];
  // Direction bit is the last header bit: one means read
  assign is_read = s_q.header[0];

  // Partial write zero-fills the low bits below the latched ones
  always_comb begin
    // Full or long frame: the newest sixteen bits as they stand
    wval = s_q.shreg;
    if (s_q.data_cnt < 5'd16) begin
      // Short frame: latched bits move to the top, the rest read zero
      wval = 16'h0000;
      for (int i = 0; i < 16; i++) begin
        if (i < 32'(s_q.data_cnt)) begin
          wval[15 - i] = s_q.shreg[32'(s_q.data_cnt) - 1 - i];
        end
      end
    end
  end

  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Two flops on every outside input before use
    // Shift clock and select get a third flop for edge detection
    s_d.sclk_sync = {s_q.sclk_sync[1:0], sclk_i};
    s_d.csn_sync = {s_q.csn_sync[1:0], csn_i};
    s_d.sdio_sync = {s_q.sdio_sync[0], sdio_i};
    s_d.external_enable_pin_sync = {s_q.external_enable_pin_sync[0], external_enable_pin_i};
    s_d.rfsel_sync = {s_q.rfsel_sync[0], rf_input_select_pin_i};
    s_d.lock_sync = {s_q.lock_sync[0], lock_detect_i};
    s_d.ref_sync = {s_q.ref_sync[0], ref_clk_div_i};
    if (!cs_active) begin
      // Select high: port idle, pins ignored
      s_d.phase = dscp_pkg::DSCP_IDLE;
      s_d.sdio_oe = 1'b0;
      s_d.bit_cnt = 5'd0;
      s_d.data_cnt = 5'd0;
      if (cs_rise && s_q.phase == dscp_pkg::DSCP_DATA && !is_read && s_q.data_cnt != 5'd0) begin
        // Commit at end of frame, only latched bits
        case (s_q.header[7:1])
          `DSCP_ADDR_PD_MASK: s_d.power_down_mask = wval;
          `DSCP_ADDR_BALUN: s_d.balun_capacitor_codes = wval;
          `DSCP_ADDR_BB_BW: s_d.baseband_bias_and_bandwidth = wval;
          `DSCP_ADDR_STATUS_SEL: s_d.status_select_reg = wval;
          // Unmapped addresses are dropped
          default: s_d.balun_capacitor_codes = s_q.balun_capacitor_codes;
        endcase
      end
    end else begin
      case (s_q.phase)
        dscp_pkg::DSCP_IDLE: begin
          // Frame opens on select low; first clock rise is address MSB
          s_d.phase = dscp_pkg::DSCP_HEAD;
          s_d.bit_cnt = 5'd0;
        end
        dscp_pkg::DSCP_HEAD: begin
          if (sclk_rise) begin
            s_d.header = {s_q.header[6:0], s_q.sdio_sync[1]};
            s_d.bit_cnt = s_q.bit_cnt + 5'd1;
            // Eighth rise completes the header; fetch the read word now
            if (s_q.bit_cnt == 5'(`DSCP_HDR_BITS - 1)) begin
              s_d.phase = dscp_pkg::DSCP_DATA;
              s_d.data_cnt = 5'd0;
              s_d.rdata = rd_mux(s_q.header[6:0], s_q);
            end
          end
        end
        dscp_pkg::DSCP_DATA: begin
          if (is_read) begin
            // Drive MSB after the clock fall following the direction bit
            if (sclk_fall) begin
              s_d.sdio_oe = 1'b1;
              s_d.sdio_out = s_q.rdata[15];
              s_d.rdata = {s_q.rdata[14:0], 1'b0};
            end
          end else if (sclk_rise) begin
            // Shift keeps going past sixteen; only the newest sixteen survive
            s_d.shreg = {s_q.shreg[14:0], s_q.sdio_sync[1]};
            // Count saturates so a long frame still commits as full
            if (s_q.data_cnt != 5'd16) begin
              s_d.data_cnt = s_q.data_cnt + 5'd1;
            end
          end
        end
        default: s_d.phase = dscp_pkg::DSCP_IDLE;
      endcase
    end
    // Settings decode; one extra flop so the core never sees a half-written word
    // Bias code straight from its field
    s_d.ctrl.buffer_bias_code = s_q.baseband_bias_and_bandwidth[`DSCP_BIAS_HI:`DSCP_BIAS_LO];
    // Modes 0 and 1 high gain, 2 and 3 low gain; the core reads the code
    s_d.ctrl.bandwidth_mode = s_q.baseband_bias_and_bandwidth[`DSCP_BW_HI:`DSCP_BW_LO];
    // Input code high nibble, output code low nibble
    s_d.ctrl.balun_input_cap_code = s_q.balun_capacitor_codes[`DSCP_BAL_IN_HI:`DSCP_BAL_IN_LO];
    s_d.ctrl.balun_output_cap_code = s_q.balun_capacitor_codes[`DSCP_BAL_OUT_HI:`DSCP_BAL_OUT_LO];
    // Mask bit set: that block follows the enable pin; clear: always on
    s_d.ctrl.block_enable = s_q.external_enable_pin_sync[1] ? 16'hFFFF : ~s_q.power_down_mask;
    // Exactly one input is routed at any time out of reset; in reset neither is
    s_d.ctrl.rf_input_first = ~s_q.rfsel_sync[1];
    s_d.ctrl.rf_input_second = s_q.rfsel_sync[1];
    // Reference only on the reference code; other codes give lock detect
    s_d.ctrl.status_output_pin = (s_q.status_select_reg[`DSCP_SSEL_HI:`DSCP_SSEL_LO] == `DSCP_SSEL_REF)
      ? s_q.ref_sync[1] : s_q.lock_sync[1];
  end

  // State register; the reset branch takes constants only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // Everything clear first, then the non-zero defaults
      s_q <= '0;
      // Select chain starts at its idle high level, so no false frame edge
      s_q.csn_sync <= 3'h7;
      s_q.baseband_bias_and_bandwidth <= `DSCP_RST_BB_BW;
      s_q.status_select_reg <= `DSCP_RST_STATUS_SEL;
      s_q.power_down_mask <= `DSCP_RST_PD_MASK;
      s_q.balun_capacitor_codes <= `DSCP_RST_BALUN;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  // No logic between the state flops and the pins
  assign sdio_o = s_q.sdio_out;
  assign sdio_oe_o = s_q.sdio_oe;
  assign ctrl_o = s_q.ctrl;

  // Checks, all on the system clock; the assertions are off during reset, the covers are not
  // Decode checks other than the enable-pin check wait until reset has been gone a cycle, so the reset decode is not judged

  // Select high: the device lets go of the data line
  a_idle_no_drive: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cs_active |=> !sdio_oe_o) else $error("data line driven while deselected");

  // Write data phase: the host owns the line
  a_write_drive_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s_q.phase == dscp_pkg::DSCP_DATA && !is_read) |-> !sdio_oe_o) else $error("drive during write");

  // Header phase: the host owns the line
  a_head_no_drive: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_q.phase == dscp_pkg::DSCP_HEAD |-> !sdio_oe_o) else $error("drive during header");

  // Drive only in the data phase
  a_oe_in_data: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sdio_oe_o |-> s_q.phase == dscp_pkg::DSCP_DATA) else $error("drive outside data phase");

  // Drive only in a read frame
  a_oe_read_only: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sdio_oe_o |-> is_read) else $error("drive in write frame");

  // Header never runs past eight bits
  a_header_len: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_q.phase == dscp_pkg::DSCP_HEAD |-> s_q.bit_cnt <= 5'd8) else $error("header overrun");

  // Only the three named phases occur
  a_phase_legal: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_q.phase inside {dscp_pkg::DSCP_IDLE, dscp_pkg::DSCP_HEAD, dscp_pkg::DSCP_DATA})
    else $error("illegal phase");

  // Eighth header rise moves to the data phase
  a_head_to_data: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_active && s_q.phase == dscp_pkg::DSCP_HEAD && sclk_rise && s_q.bit_cnt == 5'd7
    |=> s_q.phase == dscp_pkg::DSCP_DATA) else $error("data phase missed");

  // Data count saturates at sixteen
  a_data_cap: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_q.data_cnt <= 5'd16) else $error("data count overrun");

  // Long write keeps the count at sixteen
  a_data_sat: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_active && s_q.phase == dscp_pkg::DSCP_DATA && !is_read && sclk_rise && s_q.data_cnt == 5'd16
    |=> s_q.data_cnt == 5'd16) else $error("count left saturation");

  // Select low in idle opens the frame
  a_frame_open: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_active && s_q.phase == dscp_pkg::DSCP_IDLE |=> s_q.phase == dscp_pkg::DSCP_HEAD)
    else $error("frame not opened");

  // Select high returns the port to idle
  a_deselect_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cs_active |=> s_q.phase == dscp_pkg::DSCP_IDLE) else $error("port busy while deselected");

  // Select high and no frame end: registers do not move
  a_deselect_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cs_active && !cs_rise |=> $stable({s_q.power_down_mask, s_q.balun_capacitor_codes,
    s_q.baseband_bias_and_bandwidth, s_q.status_select_reg})) else $error("write while deselected");

  // End of a read frame writes nothing
  a_read_no_commit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_rise && s_q.phase == dscp_pkg::DSCP_DATA && is_read |=> $stable({s_q.power_down_mask,
    s_q.balun_capacitor_codes, s_q.baseband_bias_and_bandwidth, s_q.status_select_reg}))
    else $error("read changed a register");

  // Header bits enter at the bottom, so the first lands on top
  a_head_shift: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_active && s_q.phase == dscp_pkg::DSCP_HEAD && sclk_rise
    |=> s_q.header[0] == $past(s_q.sdio_sync[1])) else $error("header bit lost");

  // Write data taken on the clock rise
  a_data_shift: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_active && s_q.phase == dscp_pkg::DSCP_DATA && !is_read && sclk_rise
    |=> s_q.shreg[0] == $past(s_q.sdio_sync[1])) else $error("data bit lost");

  // Full write to the balun register commits the newest sixteen bits
  a_full_commit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_rise && s_q.phase == dscp_pkg::DSCP_DATA && !is_read && s_q.data_cnt == 5'd16
    && s_q.header[7:1] == `DSCP_ADDR_BALUN |=> s_q.balun_capacitor_codes == $past(s_q.shreg))
    else $error("full write lost");

  // Twelve latched bits: low nibble reads zero
  a_short_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_q.data_cnt == 5'd12 |-> wval[3:0] == 4'h0) else $error("short write fill");

  // Twelve latched bits sit at the top, first bit highest
  a_short_top: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_q.data_cnt == 5'd12 |-> wval[15:4] == s_q.shreg[11:0]) else $error("short write order");

  // Read word fetched as the header completes
  a_rdata_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_active && s_q.phase == dscp_pkg::DSCP_HEAD && sclk_rise && s_q.bit_cnt == 5'd7
    && s_q.header[6:0] == `DSCP_ADDR_BB_BW |=> s_q.rdata == $past(s_q.baseband_bias_and_bandwidth))
    else $error("read word not loaded");

  // Clock fall in a read frame turns the driver on
  a_read_drive_on: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_active && s_q.phase == dscp_pkg::DSCP_DATA && is_read && sclk_fall |=> sdio_oe_o)
    else $error("read driver off");

  // Each fall presents the top bit of the read word
  a_read_msb: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_active && s_q.phase == dscp_pkg::DSCP_DATA && is_read && sclk_fall
    |=> sdio_o == $past(s_q.rdata[15])) else $error("read bit wrong");

  // Read word moves up one place per fall
  a_read_shift: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cs_active && s_q.phase == dscp_pkg::DSCP_DATA && is_read && sclk_fall
    |=> s_q.rdata == {$past(s_q.rdata[14:0]), 1'b0}) else $error("read word not shifted");

  // Bias code follows its field one cycle late
  a_bias_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) |=> ctrl_o.buffer_bias_code == $past(s_q.baseband_bias_and_bandwidth[11:10]))
    else $error("bias lag");

  // Bandwidth mode follows its field one cycle late
  a_bw_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) |=> ctrl_o.bandwidth_mode == $past(s_q.baseband_bias_and_bandwidth[9:8]))
    else $error("mode lag");

  // Balun codes follow their field one cycle late
  a_balun_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) |=> {ctrl_o.balun_input_cap_code, ctrl_o.balun_output_cap_code}
    == $past(s_q.balun_capacitor_codes[7:0])) else $error("balun lag");

  // Never both rf inputs at once
  a_rf_exclusive: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) |=> ctrl_o.rf_input_first != ctrl_o.rf_input_second) else $error("both rf inputs");

  // Second input follows the select pin
  a_rf_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) |=> ctrl_o.rf_input_second == $past(s_q.rfsel_sync[1])) else $error("rf select lag");

  // Enable pin high turns every block on
  a_enable_all: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_q.external_enable_pin_sync[1] |=> ctrl_o.block_enable == 16'hFFFF) else $error("enable missed");

  // Enable pin low: masked blocks go down, others stay on
  a_mask_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) && !s_q.external_enable_pin_sync[1] |=> ctrl_o.block_enable == ~$past(s_q.power_down_mask))
    else $error("mask not applied");

  // Lock detect on the status pin unless the reference code is set
  a_status_lock: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) && s_q.status_select_reg[6:4] != `DSCP_SSEL_REF
    |=> ctrl_o.status_output_pin == $past(s_q.lock_sync[1])) else $error("lock not shown");

  // Reference on the status pin for the reference code
  a_status_ref: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) && s_q.status_select_reg[6:4] == `DSCP_SSEL_REF
    |=> ctrl_o.status_output_pin == $past(s_q.ref_sync[1])) else $error("reference not shown");

  // Main scenarios
  c_write_frame: cover property (@(posedge clk_i) cs_rise && !is_read && s_q.data_cnt == 5'd16);
  c_short_write: cover property (@(posedge clk_i) cs_rise && !is_read && s_q.data_cnt == 5'd4);
  c_read_frame: cover property (@(posedge clk_i) sdio_oe_o);
  // Clock activity while deselected
  c_deselect_noise: cover property (@(posedge clk_i) !cs_active && sclk_rise);
  // Reference routed to the status pin
  c_status_ref: cover property (@(posedge clk_i) s_q.status_select_reg[6:4] == `DSCP_SSEL_REF);

endmodule : dscp_top
`default_nettype wire

//--- tb/dscp_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host controller model; it changes lines only after clk_i rises
module dscp_host (
  // Clock
  input wire logic clk_i,
  // Serial lines
  output logic sclk_o,
  output logic csn_o,
  output logic sdio_o,
  output logic sdio_oe_o,
  input wire logic sdio_i
);
  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    sdio_o = 1'b0;
    sdio_oe_o = 1'b0;
  end
  // One frame: address, direction, n data bits left-aligned in wd, MSB first
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [23:0] wd, input int n,
                      output logic [15:0] rdat);
    logic [31:0] f;
    f = {a, rd, wd};
    rdat = 16'h0000;
    @(posedge clk_i) csn_o <= 1'b0;
    for (int i = 0; i < 8 + n; i++) begin
      sdio_o <= f[31-i];
      sdio_oe_o <= !(rd && i > 7); // Let go of the line after the direction bit
      sclk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      // Sampled late in the high phase for margin; bits past sixteen are dropped
      if (rd && i > 7 && i < 24) rdat[23-i] = sdio_i;
    end
    sclk_o <= 1'b0;
    sdio_oe_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    csn_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : xfer
  // Clock and data activity with select held high
  task automatic noise();
    for (int i = 0; i < 24; i++) begin
      repeat (4) @(posedge clk_i);
      sclk_o <= i[0];
      sdio_oe_o <= 1'b1;
      sdio_o <= i[1];
    end
    @(posedge clk_i) sclk_o <= 1'b0;
    sdio_oe_o <= 1'b0;
  endtask : noise
endmodule : dscp_host
`default_nettype wire

//--- tb/dscp_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
// Runs frames through the host model and checks core settings
module dscp_top_bench;
  logic clk_i, nrst_i, external_enable_pin, rfsel, lock, refc, last_q, sclk, csn, h_d, h_oe, d_o, d_oe;
  wire logic sdio_w;
  dscp_pkg::dscp_ctrl_t ctrl;
  int num_errors = 0;
  int n_compared = 0;
  logic [15:0] rd;
  // No pull on the line: released, it shows a changing pattern
  assign sdio_w = d_oe ? d_o : (h_oe ? h_d : ~last_q);
  always @(posedge clk_i) last_q <= sdio_w;
  dscp_host dscp_host_i (.clk_i(clk_i), .sclk_o(sclk), .csn_o(csn), .sdio_o(h_d), .sdio_oe_o(h_oe),
    .sdio_i(sdio_w));
  dscp_top dscp_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .csn_i(csn), .sdio_i(sdio_w),
    .sdio_o(d_o), .sdio_oe_o(d_oe), .external_enable_pin_i(external_enable_pin), .rf_input_select_pin_i(rfsel),
    .lock_detect_i(lock), .ref_clk_div_i(refc), .ctrl_o(ctrl));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    dscp_host_i.xfer(a, 1'b0, {d, 8'h00}, 16, rd);
    repeat (4) @(posedge clk_i);
  endtask : wr
  task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
    dscp_host_i.xfer(a, 1'b1, 24'h0000_00, 16, rd);
    chk(rd, exp);
  endtask : rchk
  task automatic t_reset();
    rchk(7'h10, 16'h0000);
    rchk(7'h34, 16'h0400);
    rchk(7'h21, 16'h0010);
    rchk(7'h05, 16'h0000);
  endtask : t_reset
  // Every bandwidth mode with a different bias code
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      wr(7'h34, {4'h0, ~m[1:0], m[1:0], 8'h00});
      chk(16'(ctrl.bandwidth_mode), 16'(m));
      chk(16'(ctrl.buffer_bias_code), 16'({~m[1:0]}));
      rchk(7'h34, {4'h0, ~m[1:0], m[1:0], 8'h00});
    end
    // Bias code 1 as a host would pick it for a 200 ohm load
    wr(7'h34, 16'h0500);
    chk(16'(ctrl.buffer_bias_code), 16'h0001);
  endtask : t_modes
  task automatic t_balun();
    wr(7'h30, 16'h00A5);
    chk(16'(ctrl.balun_input_cap_code), 16'h000A);
    chk(16'(ctrl.balun_output_cap_code), 16'h0005);
    dscp_host_i.xfer(7'h30, 1'b0, 24'hABC0_00, 12, rd);
    rchk(7'h30, 16'hABC0);
    dscp_host_i.xfer(7'h30, 1'b0, 24'h1234_50, 20, rd);
    rchk(7'h30, 16'h2345);
    dscp_host_i.noise();
    rchk(7'h30, 16'h2345);
  endtask : t_balun
  task automatic t_pins();
    wr(7'h10, 16'h0005);
    for (int b = 0; b < 2; b++) begin
      external_enable_pin <= b[0];
      rfsel <= b[0];
      repeat (8) @(posedge clk_i);
      chk(ctrl.block_enable, b[0] ? 16'hFFFF : 16'hFFFA);
      chk(16'(ctrl.rf_input_first), 16'(!b[0]));
      chk(16'(ctrl.rf_input_second), 16'(b[0]));
    end
  endtask : t_pins
  // Lock detect is the default; then the reference
  task automatic t_status();
    for (int c = 1; c >= 0; c--) begin
      if (c == 0) wr(7'h21, 16'h0000);
      for (int v = 0; v < 2; v++) begin
        lock <= v[0];
        refc <= !v[0];
        repeat (8) @(posedge clk_i);
        chk(16'(ctrl.status_output_pin), 16'(c[0] ? v[0] : !v[0]));
      end
    end
  endtask : t_status
  task automatic finish_test();
    $display("Errors %0d, compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  initial begin
    nrst_i = 1'b0;
    external_enable_pin = 1'b1;
    rfsel = 1'b0;
    lock = 1'b0;
    refc = 1'b0;
    last_q = 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    t_reset();
    t_status();
    t_modes();
    t_balun();
    t_pins();
    finish_test();
  end
  // About 4,500 cycles expected; cut off at 30,000
  initial begin
    #300000;
    num_errors++;
    finish_test();
  end
endmodule : dscp_top_bench
`default_nettype wire
